// >>> core/fla_core.sv
// Linear pointer array access and program/erase timing sequencer
// Notes on behaviour
// - Auto-increment read returns byte, then pointer advances
// - Auto-increment write stores byte, then pointer advances
// - Word port sits below byte port, same
// - Plain port read leaves pointer unchanged
// - Plain port write leaves pointer unchanged
// - Adjust write adds signed byte to pointer
// - 0x7f adds 127, 0x80 minus 128
// - No commands before divider sets valid clock
// - Divider accepts a single write after reset
// - Operations timed in whole timing clock periods
// - Program 9, sector 4000, mass 20000 periods
// - Chained burst byte takes 4, sector erase abort at most 4 periods
// - Program array sectors are 512 bytes
// - Data array sectors selectable four or eight
// - Pointer is 17 bits over three bytes
// - Array write before divider sets access error
`timescale 1ns/1ps
`default_nettype none
module fla_core #(
  parameter int              ADDR_W      = 17,
  parameter logic [16:0]     DATA_BASE   = 17'h1f800,
  parameter int              SECT_TICKS_P = fla_pkg::SECT_TICKS,
  parameter int              MASS_TICKS_P = fla_pkg::MASS_TICKS,
  parameter int              PRESCALE    = fla_pkg::DIV_PRESCALE
) (
  // Clock, reset, enable
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Register port
  input  wire fla_pkg::fla_req_t req,
  output logic [7:0]             reg_rdata,
  // Array read path
  output logic [ADDR_W-1:0]      mem_rd_addr,
  input  wire logic [7:0]        mem_rdata,
  // Array operations
  output fla_pkg::fla_wr_t       prog,
  output logic                   erase_en,
  output logic [ADDR_W-1:0]      erase_base,
  output logic [ADDR_W-1:0]      erase_last,
  output logic                   hv_on
);

  logic [ADDR_W-1:0]        ptr;
  logic [7:0]               div_val;
  logic                     div_loaded;
  logic                     sect8;
  logic                     acc_err;
  logic                     done;
  logic                     armed;
  logic [ADDR_W-1:0]        op_addr;
  logic [7:0]               op_data;
  logic [7:0]               op_code;
  logic [fla_pkg::CNT_W-1:0] ticks_left;
  logic                     aborted;
  logic                     burst_v;
  logic [ADDR_W-1:0]        burst_last;
  logic                     tick;
  logic [fla_pkg::PER_W-1:0] period;
  logic                     div_ok;
  logic                     inc_port;
  logic                     data_port;
  logic                     arr_wr;
  logic                     arr_ok;
  logic                     cmd_wr;
  logic                     code_ok;
  logic                     abort_hit;
  logic                     launch;
  logic                     finish;
  logic                     burst_chain;
  logic                     is_data;
  logic [ADDR_W-1:0]        sect_mask;
  logic [fla_pkg::CNT_W-1:0] next_ticks;

  typedef enum logic {FLA_IDLE, FLA_RUN} fla_state_t;
  fla_state_t state;

  // Word and byte auto-increment ports alike
  assign inc_port  = (req.addr == fla_pkg::OFS_WORD_INC) || (req.addr == fla_pkg::OFS_BYTE_INC);
  assign data_port = inc_port || (req.addr == fla_pkg::OFS_BYTE);
  assign arr_wr    = req.wr && data_port;
  assign cmd_wr    = req.wr && (req.addr == fla_pkg::OFS_COMMAND);

  assign period = (fla_pkg::PER_W'(div_val) + fla_pkg::PER_W'(1)) * fla_pkg::PER_W'(PRESCALE);
  assign div_ok = div_loaded && (period >= fla_pkg::PER_W'(fla_pkg::PER_MIN))
                  && (period <= fla_pkg::PER_W'(fla_pkg::PER_MAX));

  assign code_ok = (req.wdata == fla_pkg::CMD_BLANK) || (req.wdata == fla_pkg::CMD_PROG)
                   || (req.wdata == fla_pkg::CMD_BURST) || (req.wdata == fla_pkg::CMD_SECT)
                   || (req.wdata == fla_pkg::CMD_MASS) || (req.wdata == fla_pkg::CMD_ABORT);
  assign arr_ok    = arr_wr && div_ok && !armed && !acc_err;
  assign abort_hit = cmd_wr && armed && (req.wdata == fla_pkg::CMD_ABORT) && (state == FLA_RUN)
                     && (op_code == fla_pkg::CMD_SECT);
  assign launch    = cmd_wr && armed && code_ok && (state == FLA_IDLE);
  assign finish    = (state == FLA_RUN) && tick && (ticks_left == fla_pkg::CNT_W'(1));

  assign burst_chain = burst_v && (op_addr == burst_last + ADDR_W'(1))
                       && ((op_addr & ~ADDR_W'(fla_pkg::BURST_BLK_MASK))
                           == (burst_last & ~ADDR_W'(fla_pkg::BURST_BLK_MASK)));

  assign is_data   = op_addr >= DATA_BASE;
  assign sect_mask = !is_data ? ADDR_W'(fla_pkg::SECT_PROG_MASK)
                   : (sect8 ? ADDR_W'(fla_pkg::SECT_DATA8_MASK) : ADDR_W'(fla_pkg::SECT_DATA4_MASK));

  always_comb
  begin
    case (req.wdata)
      fla_pkg::CMD_PROG:  next_ticks = fla_pkg::CNT_W'(fla_pkg::PROG_TICKS);
      fla_pkg::CMD_BURST: next_ticks = burst_chain ? fla_pkg::CNT_W'(fla_pkg::BURST_TICKS)
                                                   : fla_pkg::CNT_W'(fla_pkg::PROG_TICKS);
      fla_pkg::CMD_SECT:  next_ticks = fla_pkg::CNT_W'(SECT_TICKS_P);
      fla_pkg::CMD_MASS:  next_ticks = fla_pkg::CNT_W'(MASS_TICKS_P);
      fla_pkg::CMD_ABORT: next_ticks = fla_pkg::CNT_W'(fla_pkg::ABORT_TICKS);
      default:            next_ticks = fla_pkg::CNT_W'(fla_pkg::BLANK_TICKS);
    endcase
  end

  fla_tick #(
    .PER_W  (fla_pkg::PER_W)
  ) u_tick (
    .mclk   (mclk),
    .rst    (rst),
    .ce     (ce),
    .run    (state == FLA_RUN),
    .period (period),
    .tick   (tick)
  );

  // Linear address pointer
  always_ff @(posedge mclk)
  begin
    if (rst)
      ptr <= '0;
    else if (ce)
    begin
      if (req.wr && req.addr == fla_pkg::OFS_PTR_HI)
        ptr[ADDR_W-1:16] <= req.wdata[ADDR_W-17:0];
      else if (req.wr && req.addr == fla_pkg::OFS_PTR_MID)
        ptr[15:8] <= req.wdata;
      else if (req.wr && req.addr == fla_pkg::OFS_PTR_LO)
        ptr[7:0] <= req.wdata;
      else if (req.wr && req.addr == fla_pkg::OFS_ADJUST)
        ptr <= ptr + ADDR_W'($signed(req.wdata));
      else if ((req.wr || req.rd) && inc_port)
        ptr <= ptr + ADDR_W'(1);
    end
  end

  // Read data
  always_ff @(posedge mclk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (ce && req.rd)
    begin
      case (req.addr)
        fla_pkg::OFS_PTR_HI:  reg_rdata <= 8'(ptr[ADDR_W-1:16]);
        fla_pkg::OFS_PTR_MID: reg_rdata <= ptr[15:8];
        fla_pkg::OFS_PTR_LO:  reg_rdata <= ptr[7:0];
        fla_pkg::OFS_WORD_INC, fla_pkg::OFS_BYTE_INC, fla_pkg::OFS_BYTE:
          reg_rdata <= mem_rdata;
        fla_pkg::OFS_DIVIDER: reg_rdata <= div_val;
        fla_pkg::OFS_STATUS:
        begin
          reg_rdata <= 8'h00;
          reg_rdata[fla_pkg::ST_DIV_LOADED] <= div_loaded;
          reg_rdata[fla_pkg::ST_DONE]       <= done;
          reg_rdata[fla_pkg::ST_BUSY]       <= state == FLA_RUN;
          reg_rdata[fla_pkg::ST_ACC_ERR]    <= acc_err;
        end
        fla_pkg::OFS_CONFIG:  reg_rdata <= {7'h00, sect8};
        default:              reg_rdata <= 8'h00;
      endcase
    end
  end

  // Divider and config
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      div_val    <= 8'h00;
      div_loaded <= 1'b0;
      sect8      <= 1'b0;
    end
    else if (ce)
    begin
      if (req.wr && req.addr == fla_pkg::OFS_DIVIDER && !div_loaded)
      begin
        div_val    <= req.wdata;
        div_loaded <= 1'b1;
      end
      if (req.wr && req.addr == fla_pkg::OFS_CONFIG)
        sect8 <= req.wdata[fla_pkg::CFG_SECT8];
    end
  end

  // Access error flag, set wins over clear
  always_ff @(posedge mclk)
  begin
    if (rst)
      acc_err <= 1'b0;
    else if (ce)
    begin
      if ((arr_wr && (!div_ok || armed)) || (cmd_wr && (!armed || !code_ok))
          || (cmd_wr && armed && code_ok && state == FLA_RUN && !abort_hit)
          || (finish && aborted))
        acc_err <= 1'b1;
      else if (req.wr && req.addr == fla_pkg::OFS_STATUS && req.wdata[fla_pkg::ST_ACC_ERR])
        acc_err <= 1'b0;
    end
  end

  // Command latch and sequencer
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state      <= FLA_IDLE;
      armed      <= 1'b0;
      op_addr    <= '0;
      op_data    <= 8'h00;
      op_code    <= 8'h00;
      ticks_left <= '0;
      aborted    <= 1'b0;
      done       <= 1'b0;
      burst_v    <= 1'b0;
      burst_last <= '0;
    end
    else if (ce)
    begin
      if (arr_ok)
      begin
        armed   <= 1'b1;
        op_addr <= ptr;
        op_data <= req.wdata;
      end
      else if (cmd_wr)
        armed <= 1'b0;
      case (state)
        FLA_IDLE:
        begin
          if (launch)
          begin
            state      <= FLA_RUN;
            op_code    <= req.wdata;
            ticks_left <= next_ticks;
            aborted    <= 1'b0;
            done       <= 1'b0;
            if (req.wdata != fla_pkg::CMD_BURST)
              burst_v <= 1'b0;
          end
        end
        FLA_RUN:
        begin
          if (abort_hit)
          begin
            aborted <= 1'b1;
            if (ticks_left > fla_pkg::CNT_W'(fla_pkg::ABORT_TICKS))
              ticks_left <= fla_pkg::CNT_W'(fla_pkg::ABORT_TICKS);
          end
          else if (finish)
          begin
            state <= FLA_IDLE;
            done  <= 1'b1;
            if (op_code == fla_pkg::CMD_BURST)
            begin
              burst_v    <= 1'b1;
              burst_last <= op_addr;
            end
          end
          else if (tick)
            ticks_left <= ticks_left - fla_pkg::CNT_W'(1);
        end
        default: state <= FLA_IDLE;
      endcase
    end
  end

  // Array operation outputs
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prog       <= '0;
      erase_en   <= 1'b0;
      erase_base <= '0;
      erase_last <= '0;
      hv_on      <= 1'b0;
    end
    else if (ce)
    begin
      hv_on     <= (state == FLA_RUN) && !finish;
      prog.en   <= finish && (op_code == fla_pkg::CMD_PROG || op_code == fla_pkg::CMD_BURST);
      prog.addr <= op_addr;
      prog.data <= op_data;
      erase_en  <= finish && !aborted && (op_code == fla_pkg::CMD_SECT || op_code == fla_pkg::CMD_MASS);
      if (op_code == fla_pkg::CMD_MASS)
      begin
        erase_base <= is_data ? DATA_BASE : '0;
        erase_last <= is_data ? '1 : DATA_BASE - ADDR_W'(1);
      end
      else
      begin
        erase_base <= op_addr & ~sect_mask;
        erase_last <= op_addr | sect_mask;
      end
    end
  end

  assign mem_rd_addr = ptr;

endmodule
`default_nettype wire

// >>> core/fla_pkg.sv
// Shared constants and carrier types for the linear access and flash timing block
package fla_pkg;

  // Register port offsets
  localparam logic [3:0] OFS_PTR_HI   = 4'h0;
  localparam logic [3:0] OFS_PTR_MID  = 4'h1;
  localparam logic [3:0] OFS_PTR_LO   = 4'h2;
  localparam logic [3:0] OFS_WORD_INC = 4'h3;
  localparam logic [3:0] OFS_BYTE_INC = 4'h4;
  localparam logic [3:0] OFS_BYTE     = 4'h5;
  localparam logic [3:0] OFS_ADJUST   = 4'h6;
  localparam logic [3:0] OFS_DIVIDER  = 4'h7;
  localparam logic [3:0] OFS_STATUS   = 4'h8;
  localparam logic [3:0] OFS_COMMAND  = 4'h9;
  localparam logic [3:0] OFS_CONFIG   = 4'ha;

  // Status and config bit positions
  localparam int ST_DIV_LOADED = 7;
  localparam int ST_DONE       = 6;
  localparam int ST_BUSY       = 5;
  localparam int ST_ACC_ERR    = 4;
  localparam int CFG_SECT8     = 0;

  // Command codes
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_PROG  = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_SECT  = 8'h40;
  localparam logic [7:0] CMD_MASS  = 8'h41;
  localparam logic [7:0] CMD_ABORT = 8'h47;

  // Operation lengths in timing clock periods
  localparam int CNT_W        = 15;
  localparam int PROG_TICKS   = 9;
  localparam int BURST_TICKS  = 4;
  localparam int SECT_TICKS   = 4000;
  localparam int MASS_TICKS   = 20000;
  localparam int ABORT_TICKS  = 4;
  localparam int BLANK_TICKS  = 9;

  // Array geometry
  localparam int SECT_PROG_MASK  = 511;
  localparam int SECT_DATA4_MASK = 3;
  localparam int SECT_DATA8_MASK = 7;
  localparam int BURST_BLK_MASK  = 31;

  // Timing clock window and bus clock rate
  localparam int MCLK_KHZ     = 250000;
  localparam int FLASH_TIMING_CLOCK_MIN_KHZ = 150;
  localparam int FLASH_TIMING_CLOCK_MAX_KHZ = 200;
  localparam int PER_W        = 16;
  localparam int PER_MIN      = (MCLK_KHZ + FLASH_TIMING_CLOCK_MAX_KHZ - 1) / FLASH_TIMING_CLOCK_MAX_KHZ;
  localparam int PER_MAX      = MCLK_KHZ / FLASH_TIMING_CLOCK_MIN_KHZ;
  localparam int DIV_PRESCALE = 8;

  // Register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } fla_req_t;

  // Array program strobe
  typedef struct packed {
    logic        en;
    logic [16:0] addr;
    logic [7:0]  data;
  } fla_wr_t;

endpackage

// >>> core/fla_tick.sv
// Timing clock tick generator dividing the bus clock
`timescale 1ns/1ps
`default_nettype none
module fla_tick #(
  parameter int PER_W = 16
) (
  // Clock and control
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             run,
  // Period in bus clock cycles
  input  wire logic [PER_W-1:0] period,
  // One-cycle tick
  output logic                  tick
);

  logic [PER_W-1:0] cnt;

  // Whole timing periods
  always_ff @(posedge mclk)
  begin
    if (rst || (ce && !run))
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else if (ce)
    begin
      if (cnt >= period - PER_W'(1))
      begin
        cnt  <= '0;
        tick <= 1'b1;
      end
      else
      begin
        cnt  <= cnt + PER_W'(1);
        tick <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// >>> testbench/fla_mem_model.sv
// Array model answering reads with an address pattern
`timescale 1ns/1ps
`default_nettype none
module fla_mem_model (
  // Read path
  input  wire logic [16:0] rd_addr,
  output logic [7:0]       rdata
);
  // Combinational array read
  assign rdata = rd_addr[7:0] ^ rd_addr[15:8] ^ {7'h0, rd_addr[16]};
endmodule
`default_nettype wire

// >>> testbench/fla_core_asserts.sv
// Port checker for the linear access and flash timing core
`timescale 1ns/1ps
`default_nettype none
module fla_core_asserts (
  // Clock and control
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              ce,
  // Register port
  input wire fla_pkg::fla_req_t req,
  input wire logic [7:0]        reg_rdata,
  // Array side
  input wire logic [16:0]       mem_rd_addr,
  input wire logic [7:0]        mem_rdata,
  input wire fla_pkg::fla_wr_t  prog,
  input wire logic              erase_en,
  input wire logic              hv_on
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [25:0] hv_cnt;
  // Cycles spent with high voltage on
  always_ff @(posedge mclk)
  begin
    if (rst || !hv_on)
      hv_cnt <= 26'h0;
    else if (ce)
      hv_cnt <= hv_cnt + 26'h1;
  end
  sequence s_acc(logic [3:0] a);
    ce && (req.rd || req.wr) && (req.addr == a);
  endsequence
  sequence s_plain_rd;
    ce && req.rd && (req.addr == fla_pkg::OFS_BYTE);
  endsequence
  a_inc_byte: assert property (s_acc(fla_pkg::OFS_BYTE_INC) |=>
    mem_rd_addr == $past(mem_rd_addr) + 17'h1) else $error("byte port did not advance pointer");
  a_inc_word: assert property (s_acc(fla_pkg::OFS_WORD_INC) |=>
    mem_rd_addr == $past(mem_rd_addr) + 17'h1) else $error("word port did not advance pointer");
  a_plain_read: assert property (s_plain_rd |=>
    (reg_rdata == $past(mem_rdata)) && $stable(mem_rd_addr)) else $error("plain read wrong");
  a_plain_write: assert property (ce && req.wr && req.addr == fla_pkg::OFS_BYTE |=>
    $stable(mem_rd_addr)) else $error("plain write moved pointer");
  a_adjust_add: assert property (ce && req.wr && req.addr == fla_pkg::OFS_ADJUST |=>
    mem_rd_addr == $past(mem_rd_addr) + {{9{$past(req.wdata[7])}}, $past(req.wdata)})
    else $error("signed adjust wrong");
  a_prog_end: assert property (prog.en |-> $past(hv_on) && !hv_on ##1 !prog.en)
    else $error("program pulse not at end of operation");
  a_erase_end: assert property (erase_en |-> $past(hv_on) && !hv_on ##1 !erase_en)
    else $error("erase pulse not at end of operation");
  a_hv_min_len: assert property ($fell(hv_on) |-> $past(hv_cnt) >= 26'd4999)
    else $error("operation shorter than four timing periods");
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the linear access and flash timing core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic        wr;
    logic [3:0]  a;
    logic [7:0]  d;
    logic [16:0] p;
  } fla_row_t;
  localparam int PER = 1256;
  localparam int SECT_N = 6;
  localparam int MASS_N = 10;
  logic              mclk = 1'b0;
  logic              rst  = 1'b1;
  fla_pkg::fla_req_t req  = '0;
  logic [7:0]        reg_rdata;
  logic [7:0]        mem_rdata;
  logic [16:0]       mem_rd_addr;
  logic [16:0]       erase_base;
  logic [16:0]       erase_last;
  fla_pkg::fla_wr_t  prog;
  logic              erase_en;
  logic              hv_on;
  int                n_errors = 0;
  int                samples_checked = 0;
  fla_row_t          rows [10];

  fla_core #(.SECT_TICKS_P(SECT_N), .MASS_TICKS_P(MASS_N)) i_dut (.mclk(mclk), .rst(rst), .ce(1'b1), .req(req),
    .reg_rdata(reg_rdata), .mem_rd_addr(mem_rd_addr), .mem_rdata(mem_rdata), .prog(prog),
    .erase_en(erase_en), .erase_base(erase_base), .erase_last(erase_last), .hv_on(hv_on));
  fla_mem_model i_mem (.rd_addr(mem_rd_addr), .rdata(mem_rdata));

  always #2 mclk = ~mclk;

  function automatic logic [7:0] pat(input logic [16:0] a);
    return a[7:0] ^ a[15:8] ^ {7'h0, a[16]};
  endfunction

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    samples_checked++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    req = {w, !w, a, d};
    @(negedge mclk);
    req = '0;
  endtask

  task automatic setp(input logic [16:0] p);
    acc(1'b1, fla_pkg::OFS_PTR_HI, {7'h0, p[16]});
    acc(1'b1, fla_pkg::OFS_PTR_MID, p[15:8]);
    acc(1'b1, fla_pkg::OFS_PTR_LO, p[7:0]);
  endtask

  // Launch a command and count cycles with high voltage on
  task automatic op(input logic [7:0] c, output logic [31:0] n);
    int k;
    n = '0;
    acc(1'b1, fla_pkg::OFS_COMMAND, c);
    for (k = 0; k < 30000 && (n == 0 || hv_on === 1'b1); k++)
    begin
      if (hv_on === 1'b1)
        n++;
      @(negedge mclk);
    end
    if (k == 30000)
    begin
      n_errors++;
      complete_run();
    end
  endtask

  task automatic ers(input logic [7:0] c, input int t, input logic [16:0] p, input logic [16:0] b,
                     input logic [16:0] l);
    logic [31:0] n;
    setp(p);
    acc(1'b1, fla_pkg::OFS_BYTE, 8'h00);
    op(c, n);
    chk("erase_len", t * PER, n);
    chk("erase", {1'b1, b, l}, {erase_en, erase_base, erase_last});
    $display("erase test at %h done", p);
  endtask

  initial
  begin
    logic [16:0] p0;
    logic [31:0] n;
    rows[0] = '{1'b1, fla_pkg::OFS_PTR_HI, 8'h01, 17'h10000};
    rows[1] = '{1'b1, fla_pkg::OFS_PTR_MID, 8'hff, 17'h1ff00};
    rows[2] = '{1'b1, fla_pkg::OFS_PTR_LO, 8'hff, 17'h1ffff};
    rows[3] = '{1'b1, fla_pkg::OFS_ADJUST, 8'h01, 17'h00000};
    rows[4] = '{1'b1, fla_pkg::OFS_ADJUST, 8'hff, 17'h1ffff};
    rows[5] = '{1'b1, fla_pkg::OFS_ADJUST, 8'h80, 17'h1ff7f};
    rows[6] = '{1'b1, fla_pkg::OFS_ADJUST, 8'h7f, 17'h1fffe};
    rows[7] = '{1'b0, fla_pkg::OFS_BYTE, 8'h00, 17'h1fffe};
    rows[8] = '{1'b0, fla_pkg::OFS_BYTE_INC, 8'h00, 17'h1ffff};
    rows[9] = '{1'b0, fla_pkg::OFS_WORD_INC, 8'h00, 17'h00000};
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    chk("reset", 32'h0, {mem_rd_addr, hv_on, erase_en, reg_rdata});
    $display("reset test done");
    foreach (rows[i])
    begin
      p0 = mem_rd_addr;
      acc(rows[i].wr, rows[i].a, rows[i].d);
      chk("pointer", rows[i].p, mem_rd_addr);
      if (!rows[i].wr)
        chk("rdata", pat(p0), reg_rdata);
    end
    $display("pointer table done");
    acc(1'b1, fla_pkg::OFS_BYTE, 8'h11);
    acc(1'b0, fla_pkg::OFS_STATUS, 8'h00);
    chk("early_write_err", 1'b1, reg_rdata[fla_pkg::ST_ACC_ERR]);
    acc(1'b1, fla_pkg::OFS_STATUS, 8'h10);
    acc(1'b1, fla_pkg::OFS_DIVIDER, 8'h9c);
    acc(1'b1, fla_pkg::OFS_DIVIDER, 8'h00);
    acc(1'b0, fla_pkg::OFS_DIVIDER, 8'h00);
    chk("divider", 8'h9c, reg_rdata);
    acc(1'b0, fla_pkg::OFS_STATUS, 8'h00);
    chk("status", 2'b10, {reg_rdata[fla_pkg::ST_DIV_LOADED], reg_rdata[fla_pkg::ST_ACC_ERR]});
    repeat (2500) @(negedge mclk);
    setp(17'h00234);
    acc(1'b1, fla_pkg::OFS_BYTE, 8'ha5);
    chk("plain_write_ptr", 17'h00234, mem_rd_addr);
    op(fla_pkg::CMD_PROG, n);
    chk("prog_len", 9 * PER, n);
    chk("prog", {1'b1, 17'h00234, 8'ha5}, prog);
    $display("program test done");
    ers(fla_pkg::CMD_SECT, SECT_N, 17'h00234, 17'h00200, 17'h003ff);
    ers(fla_pkg::CMD_SECT, SECT_N, 17'h1f805, 17'h1f804, 17'h1f807);
    acc(1'b1, fla_pkg::OFS_CONFIG, 8'h01);
    ers(fla_pkg::CMD_SECT, SECT_N, 17'h1f805, 17'h1f800, 17'h1f807);
    ers(fla_pkg::CMD_MASS, MASS_N, 17'h00100, 17'h00000, 17'h1f7ff);
    setp(17'h00240);
    acc(1'b1, fla_pkg::OFS_BYTE_INC, 8'h11);
    op(fla_pkg::CMD_BURST, n);
    chk("burst_first_len", 9 * PER, n);
    acc(1'b1, fla_pkg::OFS_WORD_INC, 8'h22);
    op(fla_pkg::CMD_BURST, n);
    chk("burst_next_len", 4 * PER, n);
    chk("burst_prog", {1'b1, 17'h00241, 8'h22}, prog);
    chk("burst_ptr", 17'h00242, mem_rd_addr);
    $display("burst test done");
    setp(17'h00400);
    acc(1'b1, fla_pkg::OFS_BYTE, 8'h00);
    acc(1'b1, fla_pkg::OFS_COMMAND, fla_pkg::CMD_SECT);
    acc(1'b1, fla_pkg::OFS_BYTE, 8'h00);
    op(fla_pkg::CMD_ABORT, n);
    chk("abort_len", 1'b1, (n > 3 * PER) && (n <= 4 * PER));
    chk("abort_no_erase", 1'b0, erase_en);
    acc(1'b0, fla_pkg::OFS_STATUS, 8'h00);
    chk("abort_err", 1'b1, reg_rdata[fla_pkg::ST_ACC_ERR]);
    $display("abort test done");
    acc(1'b1, fla_pkg::OFS_STATUS, 8'h10);
    setp(17'h00600);
    acc(1'b1, fla_pkg::OFS_BYTE, 8'h00);
    acc(1'b1, fla_pkg::OFS_COMMAND, fla_pkg::CMD_SECT);
    repeat (10) @(negedge mclk);
    chk("busy_before_reset", 1'b1, hv_on);
    rst = 1'b1;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    chk("mid_reset", 32'h0, {mem_rd_addr, hv_on, erase_en, reg_rdata});
    acc(1'b0, fla_pkg::OFS_STATUS, 8'h00);
    chk("reset_status", 8'h00, reg_rdata);
    $display("mid-run reset test done");
    complete_run();
  end
endmodule

bind fla_core fla_core_asserts i_chk (.mclk(mclk), .rst(rst), .ce(ce), .req(req), .reg_rdata(reg_rdata),
  .mem_rd_addr(mem_rd_addr), .mem_rdata(mem_rdata), .prog(prog), .erase_en(erase_en), .hv_on(hv_on));
`default_nettype wire
